// file: logic/sensor_spi_map.vh
`ifndef SENSOR_SPI_MAP_VH
`define SENSOR_SPI_MAP_VH
// frame layout
`define FRM_BITS          16
`define FRM_WR_BIT        15
`define FRM_ADDR_HI       14
`define FRM_ADDR_LO       8
`define FRM_DATA_HI       7
`define FRM_DATA_LO       0
// register file: 64 words addressed by byte address bits 6:1
`define REG_WORDS         64
`define REG_IDX_W         6
// bit counter value of the last bit of a frame
`define LAST_BIT_IDX      5'h0F
// reset value of the shift and response words
`define WORD_RST_VAL      16'h0000
// global command register: upper byte address, save bit in its data byte
`define COMMAND_REG_HI_ADDR 7'h3F
`define FLASH_SAVE_BIT    4
// flash backed words: mask of indices with backup
`define FLASH_MASK        64'h01E0_0000_03FF_FFFE
// reload walk length after reset
`define LOAD_CYCLES       7'h40
`endif

// file: logic/pin_sync.v
`timescale 1ns/10ps
// two flip-flop synchroniser for one asynchronous level
module pin_sync (
    input  wire core_clk_i,
    input  wire srst_i,
    input  wire rst_val_i,
    input  wire async_i,
    output reg  sync_o
);
    reg meta_q; // first stage, read only by second stage
    // -----------------------------
    // two stage capture
    // -----------------------------
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            meta_q <= rst_val_i;
            sync_o <= rst_val_i;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// file: logic/sensor_spi_port.v
`timescale 1ns/10ps
`include "sensor_spi_map.vh"
// How it works
// - low chip select enables port, sclk times
// - sample data input on sclk rising edge
// - shift data output on sclk falling edge
// - drive output only while chip select low
// - output returns register requested last frame
// - sixteen-bit registers, two byte addresses
// - writes land in volatile register copy
// - save bit twelve copies volatile to flash
// - reset reloads flash before operating
// - mode three, msb first, 16-bit words
// - read needs request frame then data frame
// - each write frame updates one byte
module sensor_spi_port (
    input  wire        core_clk_i,
    input  wire        srst_i,
    input  wire        cs_n_i,
    input  wire        sclk_i,
    input  wire        sdi_i,
    output reg         sdo_o,
    output wire        sdo_oe_n_o,
    output wire        ready_o,
    output reg         flash_save_o
);
    // -----------------------------
    // synchronised pins
    // -----------------------------
    wire                   cs_n_s;     // chip select after two flip-flops
    wire                   sclk_s;     // serial clock after two flip-flops
    wire                   sdi_s;      // data in after two flip-flops
    reg                    sclk_d1_q;  // synced serial clock one cycle earlier

    // chip select idles high, so it comes out of reset deselected
    pin_sync u_cs (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .rst_val_i  (1'h1),
        .async_i    (cs_n_i),
        .sync_o     (cs_n_s)
    );

    // serial clock idles high in mode three, so no false edge after reset
    pin_sync u_sclk (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .rst_val_i  (1'h1),
        .async_i    (sclk_i),
        .sync_o     (sclk_s)
    );

    // data in means nothing without an sclk edge, any reset level will do
    pin_sync u_sdi (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .rst_val_i  (1'h0),
        .async_i    (sdi_i),
        .sync_o     (sdi_s)
    );

    // -----------------------------
    // serial clock edge detect
    // -----------------------------
    wire                   rise;       // rising sclk edge inside a selected frame
    wire                   fall;       // falling sclk edge inside a selected frame

    // edges only count while the port is selected
    assign rise = sclk_s & ~sclk_d1_q & ~cs_n_s;
    assign fall = ~sclk_s & sclk_d1_q & ~cs_n_s;

    // previous sclk level, reset to the idle level of the pin
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            sclk_d1_q <= 1'h1;
        end else begin
            sclk_d1_q <= sclk_s;
        end
    end

    // -----------------------------
    // state and storage
    // -----------------------------
    localparam ST_LOAD = 2'h1;  // reloading flash into the volatile copy
    localparam ST_RUN  = 2'h2;  // serving frames

    reg  [1:0]             state_q;                   // one-hot state
    reg  [6:0]             load_cnt_q;                // reload walk index
    reg  [15:0]            vol_q   [0:`REG_WORDS-1];  // volatile copy, governs operation
    reg  [15:0]            flash_q [0:`REG_WORDS-1];  // nonvolatile copy, kept over reset
    reg  [15:0]            rx_q;                      // input shift register
    reg  [4:0]             bit_cnt_q;                 // bits taken in this frame
    reg  [15:0]            tx_q;                      // output shift register
    reg  [15:0]            resp_q;                    // word owed to the next frame
    reg                    save_req_q;                // flash save pending

    // -----------------------------
    // frame decode
    // -----------------------------
    wire                   run;        // reload finished, frames are served
    wire [15:0]            frame;      // word as it stands on the 16th rising edge
    wire                   done;       // last bit of a frame taken this cycle
    wire [`REG_IDX_W-1:0]  idx;        // word index from the byte address
    wire                   hi_byte;    // address names the upper byte
    wire                   is_wr;      // write flag of the frame
    wire                   is_save;    // frame sets the save bit of the command register

    assign run     = state_q[1];
    // the bit on the line now completes the word
    assign frame   = {rx_q[14:0], sdi_s};
    // frames that arrive during the reload are ignored
    assign done    = run & rise & (bit_cnt_q == `LAST_BIT_IDX);
    assign idx     = frame[`FRM_ADDR_HI:`FRM_ADDR_LO+1];
    assign hi_byte = frame[`FRM_ADDR_LO];
    assign is_wr   = frame[`FRM_WR_BIT];
    // only a write of the upper command byte with the save bit starts a save
    assign is_save = is_wr & (frame[`FRM_ADDR_HI:`FRM_ADDR_LO] == `COMMAND_REG_HI_ADDR)
                   & frame[`FLASH_SAVE_BIT];

    // -----------------------------
    // status and enable outputs
    // -----------------------------
    // ready tells the outside that the reload is over
    assign ready_o    = run;
    // the data out pin is driven only while selected
    assign sdo_oe_n_o = cs_n_s;

    // -----------------------------
    // reload walk
    // -----------------------------
    // after every reset the flash copy is walked into the volatile copy,
    // one word per cycle, before any frame is served
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            state_q    <= ST_LOAD;
            load_cnt_q <= 7'h00;
        end else begin
            case (state_q)
                ST_LOAD: begin
                    load_cnt_q <= load_cnt_q + 7'h01;
                    // last word loaded, start serving
                    if (load_cnt_q == `LOAD_CYCLES - 7'h01) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // stay here until the next reset
                    state_q <= ST_RUN;
                end
                default: begin
                    // illegal code, start over with a reload
                    state_q    <= ST_LOAD;
                    load_cnt_q <= 7'h00;
                end
            endcase
        end
    end

    // -----------------------------
    // receive shift and bit count
    // -----------------------------
    // a deselect clears the count, so a cut frame leaves nothing behind
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            rx_q      <= `WORD_RST_VAL;
            bit_cnt_q <= 5'h00;
        end else if (!run || cs_n_s) begin
            // idle or reloading: wait for the first bit of a frame
            bit_cnt_q <= 5'h00;
        end else if (rise) begin
            rx_q <= frame;
            if (done) begin
                // wrap after the sixteenth bit for the next word
                bit_cnt_q <= 5'h00;
            end else begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // -----------------------------
    // transmit shift
    // -----------------------------
    // the word captured at the end of one frame goes out in the next,
    // one bit per falling edge, msb first
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            tx_q   <= `WORD_RST_VAL;
            resp_q <= `WORD_RST_VAL;
            sdo_o  <= 1'h0;
        end else if (done) begin
            // read the addressed word before a write to it lands
            resp_q <= vol_q[idx];
            tx_q   <= vol_q[idx];
        end else if (cs_n_s) begin
            // deselected: line up the owed word for the first falling edge
            tx_q <= resp_q;
        end else if (fall && run) begin
            // falling edge: next bit onto the line
            sdo_o <= tx_q[15];
            tx_q  <= {tx_q[14:0], 1'h0};
        end
    end

    // -----------------------------
    // flash save request
    // -----------------------------
    // the save bit starts one copy of the backed words into flash; nothing
    // is ever saved on its own
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            save_req_q   <= 1'h0;
            flash_save_o <= 1'h0;
        end else begin
            // pulse out in the cycle that the copy is made
            flash_save_o <= save_req_q;
            if (done && is_save) begin
                // a new request wins over clearing the old one
                save_req_q <= 1'h1;
            end else begin
                save_req_q <= 1'h0;
            end
        end
    end

    // -----------------------------
    // register words
    // -----------------------------
    // per word: reload, byte writes from frames, and flash save
    genvar g;
    generate
        for (g = 0; g < `REG_WORDS; g = g + 1) begin : g_word
            localparam [63:0] MASK = `FLASH_MASK;  // words with flash backup

            // volatile word: reload first, then byte writes from frames
            always @(posedge core_clk_i) begin
                if (state_q[0] && load_cnt_q[5:0] == g) begin
                    // words without backup come back cleared
                    vol_q[g] <= MASK[g] ? flash_q[g] : `WORD_RST_VAL;
                end else if (done && is_wr && idx == g) begin
                    // one byte per write frame
                    if (hi_byte) begin
                        vol_q[g][15:8] <= frame[`FRM_DATA_HI:`FRM_DATA_LO];
                    end else begin
                        vol_q[g][7:0]  <= frame[`FRM_DATA_HI:`FRM_DATA_LO];
                    end
                end
            end

            // flash word: written only by a save, untouched by reset
            always @(posedge core_clk_i) begin
                if (save_req_q && MASK[g]) begin
                    flash_q[g] <= vol_q[g];
                end
            end
        end
    endgenerate
endmodule

// file: tb/sensor_spi_port_sva.sv
`timescale 1ns/10ps
// pin level checks on the serial register port
module sensor_spi_port_sva (
    input wire core_clk_i,
    input wire srst_i,
    input wire cs_n_i,
    input wire sclk_i,
    input wire sdo_o,
    input wire sdo_oe_n_o,
    input wire ready_o,
    input wire flash_save_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // select and deselect held long enough to pass the synchroniser
    sequence s_sel; (!cs_n_i)[*4]; endsequence
    sequence s_desel; cs_n_i[*4]; endsequence
    property p_oe_on; s_sel |-> !sdo_oe_n_o; endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe late");
    property p_oe_off; s_desel |-> sdo_oe_n_o; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe stuck");
    property p_oe_rise; $rose(sdo_oe_n_o) |-> $past(cs_n_i, 2); endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("oe off early");
    property p_oe_fall; $fell(sdo_oe_n_o) |-> !$past(cs_n_i, 2); endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("oe on early");
    property p_load; $fell(srst_i) |-> !ready_o[*8]; endproperty
    a_load: assert property (p_load) else $error("no reload");
    property p_rdy; ready_o |=> ready_o; endproperty
    a_rdy: assert property (p_rdy) else $error("ready dropped");
    property p_save; flash_save_o |=> !flash_save_o; endproperty
    a_save: assert property (p_save) else $error("save long");
    property p_hold; (sclk_i && !cs_n_i)[*3] |-> $stable(sdo_o); endproperty
    a_hold: assert property (p_hold) else $error("sdo moved");
endmodule
bind sensor_spi_port sensor_spi_port_sva chk (.core_clk_i, .srst_i, .cs_n_i,
    .sclk_i, .sdo_o, .sdo_oe_n_o, .ready_o, .flash_save_o);

// file: tb/spi_host_model.sv
`timescale 1ns/10ps
// serial bus master, idles with clock high
module spi_host_model (
    input  wire  clk_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o,
    input  wire  sdo_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        sdi_o = 1'b0;
    end
    // send n bits of w msb first, collect the returned word in r
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        @(posedge clk_i);
        #3 cs_n_o = 1'b0;
        #64;
        for (int i = 15; i > 15 - n; i--) begin
            sclk_o = 1'b0;
            sdi_o = w[i];
            #32 sclk_o = 1'b1;
            #24 r[i] = sdo_i;
            #8;
        end
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #15400;
    endtask
endmodule

// file: tb/sensor_spi_port_test.sv
`timescale 1ns/10ps
// self-checking bench for the serial register port
module sensor_spi_port_test;
    logic        core_clk_i;
    logic        srst_i;
    wire         cs_n, sclk, sdi, sdo, oe_n, ready, save;
    wire         pin = (oe_n === 1'b0) ? sdo : 1'bz; // shared data out line
    logic [15:0] rd;
    logic [15:0] saves = 16'h0000; // save pulses seen
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    sensor_spi_port uut (.core_clk_i(core_clk_i), .srst_i(srst_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(oe_n),
        .ready_o(ready), .flash_save_o(save));
    spi_host_model host (.clk_i(core_clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
        .sdo_i(pin));
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    // count save pulses, cut a hang short
    always @(posedge core_clk_i) begin
        saves <= saves + {15'h0000, save === 1'b1};
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic t_load();
        repeat (60) @(posedge core_clk_i);
        check(ready, 1'b0);
        for (int i = 0; i < 200 && ready !== 1'b1; i++) @(posedge core_clk_i);
        check(ready, 1'b1);
        check(oe_n, 1'b1);
    endtask
    // both bytes of word 5, then a read overlapped with an upper byte write
    task automatic t_bytes();
        host.xfer(16'h8B5A, 16, rd);
        host.xfer(16'h8AA5, 16, rd);
        host.xfer(16'h0A00, 16, rd);
        host.xfer(16'h8B3C, 16, rd);
        check(rd, 16'h5AA5);
        host.xfer(16'h0A00, 16, rd);
        host.xfer(16'h0000, 16, rd);
        check(rd, 16'h3CA5);
    endtask
    // half a write frame must leave the register alone
    task automatic t_abort();
        host.xfer(16'h8B00, 8, rd);
        host.xfer(16'h0A00, 16, rd);
        host.xfer(16'h0A00, 16, rd);
        check(rd, 16'h3CA5);
    endtask
    task automatic t_save();
        host.xfer(16'hBF10, 16, rd);
        check(saves, 16'h0001);
        host.xfer(16'hBF08, 16, rd);
        check(saves, 16'h0001);
    endtask
    // mid-run reset: unsaved writes lost, saved word back, unbacked word cleared
    task automatic t_reload();
        host.xfer(16'h8A11, 16, rd);
        host.xfer(16'h8077, 16, rd);
        @(posedge core_clk_i);
        #3 srst_i = 1'b1;
        repeat (8) @(posedge core_clk_i);
        #3 srst_i = 1'b0;
        t_load();
        host.xfer(16'h0A00, 16, rd);
        host.xfer(16'h0000, 16, rd);
        check(rd, 16'h3CA5);
        host.xfer(16'h0000, 16, rd);
        check(rd, 16'h0000);
    endtask
    initial begin
        srst_i = 1'b1;
        repeat (8) @(posedge core_clk_i);
        #3 srst_i = 1'b0;
        t_load();
        t_bytes();
        t_abort();
        t_save();
        t_reload();
        report_and_stop();
    end
endmodule
